/* logic/vch_handler.sv */
// Channel registers, mailbox and per-channel message handling.
// Assumes a frame engine on the same clock that reports frames, bytes
// and transmit results; retries are counted there.
`timescale 1ns/1ps
module vch_handler (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic [7:0]  cpu_addr_in,
    input  wire logic        cpu_wr_in,
    input  wire logic [7:0]  cpu_wdata_in,
    output logic      [7:0]  cpu_rdata_out,
    input  wire logic        rx_start_in,
    input  wire logic [11:0] rx_id_in,
    input  wire logic        rx_rak_in,
    input  wire logic        rx_rnw_in,
    input  wire logic        rx_rtr_in,
    input  wire logic        rx_byte_valid_in,
    input  wire logic [7:0]  rx_byte_in,
    input  wire logic        rx_end_in,
    input  wire logic        rx_good_in,
    input  wire logic [4:0]  rx_len_in,
    output logic             tx_req_out,
    output logic      [3:0]  tx_chan_out,
    input  wire logic        tx_start_in,
    input  wire logic        tx_done_in,
    input  wire logic        tx_reply_in,
    input  wire logic [4:0]  tx_idx_in,
    output logic      [7:0]  tx_byte_out,
    output logic             reply_out,
    output logic             evt_out,
    output logic      [3:0]  evt_chan_out
);
    localparam int N = vch_pkg::NCH;
    logic [11:0] tag [N];
    logic [11:0] msk [N];
    logic [6:0]  ptr [N];
    logic [4:0]  len [N];
    logic [N-1:0] ext, rak, rnw, rtr, cher, chan_tx_status, chan_rx_status;
    logic [7:0]  mbox [128];
    vch_pkg::vch_type_t ty [N];
    logic [N-1:0] hit_vec, tx_vec;
    logic        hit_any, tx_any;
    logic [3:0]  hit_ch, tx_sel, fch;
    logic        cap_act, cap_tx, tx_busy;
    logic [3:0]  cap_ch;
    logic [4:0]  cap_cnt;
    logic [2:0]  cap_cmd;
    logic [11:0] cap_id;
    logic        store_en, stat_en, rx_fin, tx_fin;
    logic [6:0]  wr_idx, stat_idx;
    logic [4:0]  stat_len;
    logic [3:0]  wch;
    logic [2:0]  woff;
    logic        wreg;

    always_comb begin
        hit_vec = '0;
        tx_vec  = '0;
        for (int i = 0; i < N; i++) begin
            ty[i] = vch_pkg::msg_type(rnw[i], rtr[i], chan_tx_status[i], chan_rx_status[i]);
            if ((((rx_id_in ^ tag[i]) & msk[i]) == 12'h000)
                && (rx_rnw_in ? (ty[i] == vch_pkg::T_REPLY_IMM
                                 || ty[i] == vch_pkg::T_REPLY_DET)
                              : (ty[i] == vch_pkg::T_RX
                                 || ty[i] == vch_pkg::T_RREQ_WAIT))) begin
                hit_vec[i] = 1'b1;
            end
            tx_vec[i] = ty[i] inside {vch_pkg::T_TX, vch_pkg::T_RREQ,
                                      vch_pkg::T_REPLY_DEF, vch_pkg::T_ILLEGAL};
        end
    end

    // Scanning downward leaves the lowest set index in the result.
    always_comb begin
        hit_any = |hit_vec;
        tx_any  = |tx_vec;
        hit_ch  = 4'h0;
        tx_sel  = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_ch = 4'(i);
            end
            if (tx_vec[i]) begin
                tx_sel = 4'(i);
            end
        end
    end

    // Only buffer-free receiving types store; the illegal request does not.
    always_comb begin
        store_en = cap_act && rx_byte_valid_in
                   && (ty[cap_ch] inside {vch_pkg::T_RX, vch_pkg::T_RREQ_WAIT,
                                          vch_pkg::T_RREQ})
                   && ({1'b0, cap_cnt} + 6'h01 < {1'b0, len[cap_ch]});
        wr_idx   = ptr[cap_ch] + 7'h01 + {2'h0, cap_cnt};
        rx_fin   = rx_end_in && rx_good_in && cap_act && !cap_tx;
        tx_fin   = tx_done_in && tx_busy;
        stat_en  = (rx_fin && ty[cap_ch] inside {vch_pkg::T_RX, vch_pkg::T_RREQ_WAIT})
                   || (tx_fin && tx_reply_in && ty[tx_chan_out] == vch_pkg::T_RREQ);
        stat_idx = tx_fin ? ptr[tx_chan_out] : ptr[cap_ch];
        stat_len = rx_len_in;
        fch      = reply_out ? cap_ch : tx_chan_out;
        wreg     = cpu_wr_in && cpu_addr_in >= vch_pkg::CH_BASE
                   && cpu_addr_in < vch_pkg::MBOX_BASE;
        wch      = 4'((cpu_addr_in - vch_pkg::CH_BASE) >> 3);
        woff     = cpu_addr_in[2:0];
    end

    // Software writes first so that a hardware set in the same cycle wins.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < N; i++) begin
                tag[i] <= 12'h000;
                msk[i] <= 12'h000;
                ptr[i] <= 7'h00;
                len[i] <= 5'h00;
            end
            {ext, rak, rnw, rtr, cher} <= '0;
            chan_tx_status <= {N{vch_pkg::RST_STATUS[1]}};
            chan_rx_status <= {N{vch_pkg::RST_STATUS[0]}};
        end else begin
            if (wreg) begin
                unique case (woff)
                    vch_pkg::OFF_TAG_HI: tag[wch][11:4] <= cpu_wdata_in;
                    vch_pkg::OFF_TAG_LO: begin
                        tag[wch][3:0] <= cpu_wdata_in[7:4];
                        {ext[wch], rak[wch], rnw[wch], rtr[wch]} <= cpu_wdata_in[3:0];
                    end
                    vch_pkg::OFF_PTR:    ptr[wch] <= cpu_wdata_in[6:0];
                    vch_pkg::OFF_LEN: begin
                        len[wch] <= cpu_wdata_in[7:3];
                        {cher[wch], chan_tx_status[wch], chan_rx_status[wch]} <= cpu_wdata_in[2:0];
                    end
                    vch_pkg::OFF_MSK_LO: msk[wch][3:0] <= cpu_wdata_in[7:4];
                    vch_pkg::OFF_MSK_HI: msk[wch][11:4] <= cpu_wdata_in;
                    default: ;
                endcase
            end
            if (rx_fin) begin
                tag[cap_ch]  <= cap_id;
                chan_rx_status[cap_ch] <= 1'b1;
                if (ty[cap_ch] == vch_pkg::T_REPLY_IMM) begin
                    chan_tx_status[cap_ch] <= 1'b1;
                end
            end
            if (tx_fin) begin
                chan_tx_status[tx_chan_out] <= 1'b1;
                if (ty[tx_chan_out] == vch_pkg::T_RREQ && tx_reply_in) begin
                    chan_rx_status[tx_chan_out] <= 1'b1;
                end
            end
        end
    end

    // Capture context for one frame, from a hit or from our own request.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {cap_act, cap_tx, reply_out} <= 3'h0;
            cap_ch  <= 4'h0;
            cap_cnt <= 5'h00;
            cap_cmd <= 3'h0;
            cap_id  <= 12'h000;
        end else if (rx_start_in && hit_any) begin
            {cap_act, cap_tx} <= 2'b10;
            cap_ch    <= hit_ch;
            cap_cnt   <= 5'h00;
            cap_cmd   <= {rx_rak_in, rx_rnw_in, rx_rtr_in};
            cap_id    <= rx_id_in;
            reply_out <= ty[hit_ch] == vch_pkg::T_REPLY_IMM;
        end else if (tx_start_in && tx_req_out) begin
            {cap_act, cap_tx} <= 2'b11;
            cap_ch  <= tx_chan_out;
            cap_cnt <= 5'h00;
            cap_cmd <= {rak[tx_chan_out], rnw[tx_chan_out], rtr[tx_chan_out]};
        end else if (rx_end_in || tx_done_in) begin
            {cap_act, reply_out} <= 2'b00;
        end else if (cap_act && rx_byte_valid_in && cap_cnt != vch_pkg::LEN_MAX) begin
            cap_cnt <= cap_cnt + 5'h01;
        end
    end

    // Status written for receivers and for a reply request answered in-frame; other transmit buffers keep byte 0 as is.
    always_ff @(posedge clock_in) begin
        if (stat_en) begin
            mbox[stat_idx] <= {cap_cmd, stat_len};
        end else if (store_en) begin
            mbox[wr_idx] <= rx_byte_in;
        end else if (cpu_wr_in && cpu_addr_in[7]) begin
            mbox[cpu_addr_in[6:0]] <= cpu_wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_busy     <= 1'b0;
            tx_req_out  <= 1'b0;
            tx_chan_out <= 4'h0;
        end else if (tx_busy) begin
            tx_busy    <= !tx_done_in;
            tx_req_out <= 1'b0;
        end else if (tx_start_in && tx_req_out) begin
            tx_busy    <= 1'b1;
            tx_req_out <= 1'b0;
        end else begin
            tx_req_out  <= tx_any;
            tx_chan_out <= tx_sel;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_byte_out  <= 8'h00;
            evt_out      <= 1'b0;
            evt_chan_out <= 4'h0;
        end else begin
            tx_byte_out  <= mbox[ptr[fch] + 7'h01 + {2'h0, tx_idx_in}];
            evt_out      <= rx_fin || tx_fin;
            evt_chan_out <= tx_fin ? tx_chan_out : cap_ch;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cpu_rdata_out <= 8'h00;
        end else if (cpu_addr_in[7]) begin
            cpu_rdata_out <= mbox[cpu_addr_in[6:0]];
        end else if (cpu_addr_in >= vch_pkg::CH_BASE) begin
            unique case (woff)
                vch_pkg::OFF_TAG_HI: cpu_rdata_out <= tag[wch][11:4];
                vch_pkg::OFF_TAG_LO: cpu_rdata_out <= {tag[wch][3:0], ext[wch],
                                                      rak[wch], rnw[wch], rtr[wch]};
                vch_pkg::OFF_PTR:    cpu_rdata_out <= {1'b0, ptr[wch]};
                vch_pkg::OFF_LEN:    cpu_rdata_out <= {len[wch], cher[wch],
                                                      chan_tx_status[wch], chan_rx_status[wch]};
                vch_pkg::OFF_MSK_LO: cpu_rdata_out <= {msk[wch][3:0], 4'h0};
                vch_pkg::OFF_MSK_HI: cpu_rdata_out <= msk[wch][11:4];
                default:             cpu_rdata_out <= 8'h00;
            endcase
        end else begin
            cpu_rdata_out <= 8'h00;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    property p_stat;
        stat_en |=> mbox[$past(stat_idx)] == $past({cap_cmd, rx_len_in});
    endproperty
    a_stat: assert property (p_stat) else $error("status byte wrong");
    property p_store;
        store_en && !stat_en |=> mbox[$past(wr_idx)] == $past(rx_byte_in);
    endproperty
    a_store: assert property (p_store) else $error("data byte lost");
    property p_hit_low;
        hit_any |-> (hit_vec & ~(hit_vec - 1'b1)) == (N'(1) << hit_ch);
    endproperty
    a_hit_low: assert property (p_hit_low) else $error("hit not lowest");
    property p_tx_low;
        tx_any |-> (tx_vec & ~(tx_vec - 1'b1)) == (N'(1) << tx_sel);
    endproperty
    a_tx_low: assert property (p_tx_low) else $error("tx not lowest");
    property p_tx_done;
        tx_fin && ty[tx_chan_out] == vch_pkg::T_TX
            |=> chan_tx_status[$past(tx_chan_out)] && $stable(chan_rx_status);
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx status wrong");
    property p_inframe;
        tx_fin && tx_reply_in && ty[tx_chan_out] == vch_pkg::T_RREQ
            |=> chan_tx_status[$past(tx_chan_out)] && chan_rx_status[$past(tx_chan_out)];
    endproperty
    a_inframe: assert property (p_inframe) else $error("reply bits wrong");
    property p_rx_hit;
        rx_fin |=> chan_rx_status[$past(cap_ch)] && tag[$past(cap_ch)] == $past(cap_id);
    endproperty
    a_rx_hit: assert property (p_rx_hit) else $error("rx hit not applied");
    property p_illegal;
        cap_act && ty[cap_ch] == vch_pkg::T_ILLEGAL |-> !store_en;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal stored");
endmodule : vch_handler

/* logic/vch_pkg.sv */
// Constants and types shared by the VAN channel message handler.
// Assumes one 8-bit register map: channel sets below the mailbox.
package vch_pkg;
    localparam int         NCH        = 14;
    localparam logic [7:0] CH_BASE    = 8'h10;
    localparam logic [7:0] MBOX_BASE  = 8'h80;
    localparam logic [2:0] OFF_TAG_HI = 3'h0;
    localparam logic [2:0] OFF_TAG_LO = 3'h1;
    localparam logic [2:0] OFF_PTR    = 3'h2;
    localparam logic [2:0] OFF_LEN    = 3'h3;
    localparam logic [2:0] OFF_MSK_LO = 3'h6;
    localparam logic [2:0] OFF_MSK_HI = 3'h7;
    // Status byte: command copies in 7..5, received length in 4..0.
    localparam int         ST_RAK     = 7;
    localparam int         ST_RNW     = 6;
    localparam int         ST_RTR     = 5;
    localparam logic [1:0] RST_STATUS = 2'h3;
    localparam logic [4:0] LEN_MAX    = 5'h1f;

    typedef enum {
        T_TX, T_RX, T_RREQ, T_RREQ_WAIT, T_REPLY_IMM,
        T_REPLY_DEF, T_REPLY_DET, T_ILLEGAL, T_INACTIVE
    } vch_type_t;

    function automatic vch_type_t msg_type(input logic rnw, input logic rtr,
                                           input logic tx, input logic rx);
        unique case ({rnw, rtr})
            2'b00: return (tx | rx) ? T_INACTIVE : T_TX;
            2'b01: return (tx | rx) ? T_INACTIVE : T_RX;
            2'b11: return rx ? (tx ? T_INACTIVE : T_ILLEGAL)
                             : (tx ? T_RREQ_WAIT : T_RREQ);
            2'b10: return (tx & rx) ? T_INACTIVE : tx ? T_REPLY_DET
                         : rx ? T_REPLY_DEF : T_REPLY_IMM;
        endcase
    endfunction : msg_type
endpackage : vch_pkg

/* testbench/vch_engine.sv */
// Frame engine stand-in on the transmit side of the channel handler.
// Assumes the handler's clock and reset; it serves one request at a time.
`timescale 1ns/1ps
module vch_engine (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic        en_in,
    input  wire logic [3:0]  dly_in,
    input  wire logic [15:0] reply_map_in,
    input  wire logic        tx_req_in,
    input  wire logic [3:0]  tx_chan_in,
    output logic             tx_start_out,
    output logic             tx_done_out,
    output logic             tx_reply_out,
    output logic      [4:0]  tx_idx_out
);
    logic       busy;
    logic [3:0] cnt;
    assign tx_idx_out = {1'b0, cnt};
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy         <= 1'b0;
            cnt          <= 4'h0;
            tx_start_out <= 1'b0;
            tx_done_out  <= 1'b0;
            tx_reply_out <= 1'b0;
        end else begin
            tx_start_out <= 1'b0;
            tx_done_out  <= 1'b0;
            if (!busy && !tx_done_out && en_in && tx_req_in) begin
                tx_start_out <= 1'b1;
                busy         <= 1'b1;
                cnt          <= dly_in;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                // Completion is only reported after a whole frame, never mid-frame.
                tx_done_out  <= 1'b1;
                tx_reply_out <= reply_map_in[tx_chan_in];
                busy         <= 1'b0;
            end
        end
    end
endmodule : vch_engine

/* testbench/vch_handler_bench.sv */
// Self-checking bench for the channel handler and its engine stand-in.
// Assumes one 100 MHz clock; receive frames are driven from here.
`timescale 1ns/1ps
module vch_handler_bench;
    localparam logic [2:0] LN = vch_pkg::OFF_LEN;
    logic        clock_in = 1'b0, rstn_in = 1'b0;
    logic [7:0]  cpu_addr_in = 8'h00, cpu_wdata_in = 8'h00, rx_byte_in = 8'h00;
    logic        cpu_wr_in = 1'b0, rx_start_in = 1'b0, rx_rak_in = 1'b0, rx_rnw_in = 1'b0;
    logic        rx_rtr_in = 1'b0, rx_byte_valid_in = 1'b0, rx_end_in = 1'b0, rx_good_in = 1'b0;
    logic [11:0] rx_id_in = 12'h000;
    logic [4:0]  rx_len_in = 5'h00, tx_idx_in;
    logic        tx_start_in, tx_done_in, tx_reply_in, tx_req_out, reply_out, evt_out;
    logic [7:0]  cpu_rdata_out, tx_byte_out;
    logic [3:0]  tx_chan_out, evt_chan_out, dly = 4'h0;
    logic [15:0] rmap = 16'h0000;
    logic        en = 1'b0, rd_v = 1'b0, rd_d = 1'b0;
    logic [31:0] seed = 32'h000102d0;
    logic [7:0]  dat [4];
    logic [3:0]  ord [6] = '{4'd2, 4'd4, 4'd7, 4'd9, 4'd10, 4'd12};
    logic [7:0]  rd_q [$];
    logic [3:0]  evt_q [$];
    int          fails = 0, total_checks = 0, cyc = 0;

    always #5 clock_in = ~clock_in;

    vch_handler DUT (.clock_in, .rstn_in, .cpu_addr_in, .cpu_wr_in, .cpu_wdata_in,
        .cpu_rdata_out, .rx_start_in, .rx_id_in, .rx_rak_in, .rx_rnw_in, .rx_rtr_in,
        .rx_byte_valid_in, .rx_byte_in, .rx_end_in, .rx_good_in, .rx_len_in, .tx_req_out,
        .tx_chan_out, .tx_start_in, .tx_done_in, .tx_reply_in, .tx_idx_in, .tx_byte_out,
        .reply_out, .evt_out, .evt_chan_out);
    vch_engine eng (.clock_in, .rstn_in, .en_in(en), .dly_in(dly), .reply_map_in(rmap),
        .tx_req_in(tx_req_out), .tx_chan_in(tx_chan_out), .tx_start_out(tx_start_in),
        .tx_done_out(tx_done_in), .tx_reply_out(tx_reply_in), .tx_idx_out(tx_idx_in));

    task automatic conclude();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    function automatic logic [7:0] cb(input logic [3:0] ch, input logic [2:0] off);
        return vch_pkg::CH_BASE + {1'b0, ch, off};
    endfunction : cb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        cpu_addr_in  <= a;
        cpu_wdata_in <= d;
        cpu_wr_in    <= 1'b1;
        @(posedge clock_in);
        cpu_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_in);
        cpu_addr_in <= a;
        rd_q.push_back(e);
        rd_v <= 1'b1;
        @(posedge clock_in);
        rd_v <= 1'b0;
    endtask : rd

    // The status write goes last so the channel only wakes up fully programmed.
    task automatic sch(input logic [3:0] ch, input logic [11:0] tag, input logic [3:0] cmd,
                       input logic [6:0] ptr, input logic [1:0] st, input logic [11:0] msk);
        wr(cb(ch, vch_pkg::OFF_TAG_HI), tag[11:4]);
        wr(cb(ch, vch_pkg::OFF_TAG_LO), {tag[3:0], cmd});
        wr(cb(ch, vch_pkg::OFF_PTR), {1'b0, ptr});
        wr(cb(ch, vch_pkg::OFF_MSK_LO), {msk[3:0], 4'h0});
        wr(cb(ch, vch_pkg::OFF_MSK_HI), msk[11:4]);
        wr(cb(ch, LN), {(ch == 4'd3) ? 5'd6 : (ch == 4'd11) ? 5'd4 : 5'd3, 1'b0, st});
    endtask : sch

    task automatic rxf(input logic [11:0] id, input logic [2:0] cmd, input int n,
                       input logic [4:0] len, input logic good, input logic rep);
        @(posedge clock_in);
        rx_start_in <= 1'b1;
        rx_id_in    <= id;
        {rx_rak_in, rx_rnw_in, rx_rtr_in} <= cmd;
        for (int k = 0; k < n; k++) begin
            @(posedge clock_in);
            rx_start_in      <= 1'b0;
            rx_byte_valid_in <= 1'b1;
            rx_byte_in       <= dat[k];
        end
        @(posedge clock_in);
        rx_start_in      <= 1'b0;
        rx_byte_valid_in <= 1'b0;
        rx_end_in        <= 1'b1;
        rx_good_in       <= good;
        rx_len_in        <= len;
        #1 cmp({7'h0, reply_out}, {7'h0, rep});
        @(posedge clock_in);
        rx_end_in <= 1'b0;
    endtask : rxf

    always @(posedge clock_in) begin
        cyc  <= cyc + 1;
        rd_d <= rd_v;
        if (rd_d) cmp(cpu_rdata_out, rd_q.pop_front());
        if (rstn_in && evt_out === 1'b1) begin
            cmp({4'h0, evt_chan_out}, {4'h0, evt_q.size() ? evt_q.pop_front() : 4'hx});
        end
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        dly = 4'(rnd() % 8);
        for (int k = 0; k < 4; k++) dat[k] = rnd();
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        rd(8'h05, 8'h00);
        rd(cb(4'd0, LN), 8'h03);
        rd(cb(4'd1, 3'h4), 8'h00);
        wr(8'h93, 8'hee);
        wr(8'ha0, 8'h77);
        wr(8'he8, 8'h5c);
        wr(8'he9, 8'h96);
        sch(4'd3, 12'h5a3, 4'h1, 7'h7d, 2'b00, 12'hff0);
        sch(4'd5, 12'h5a3, 4'h1, 7'h10, 2'b00, 12'hff0);
        sch(4'd11, 12'h123, 4'h1, 7'h20, 2'b00, 12'hfff);
        evt_q.push_back(4'd3);
        rxf(12'h5a9, 3'b101, 4, 5'd3, 1'b1, 1'b0);
        evt_q.push_back(4'd5);
        rxf(12'h5ac, 3'b101, 4, 5'd3, 1'b1, 1'b0);
        rxf(12'h123, 3'b001, 2, 5'd3, 1'b0, 1'b0);
        rd(8'hfd, 8'ha3);
        rd(8'hfe, dat[0]);
        rd(8'h80, dat[2]);
        rd(8'h81, dat[3]);
        rd(cb(4'd3, vch_pkg::OFF_TAG_LO), 8'h91);
        rd(cb(4'd3, LN), 8'h31);
        rd(8'h90, 8'ha3);
        rd(8'h92, dat[1]);
        rd(8'h93, 8'hee);
        rd(cb(4'd5, vch_pkg::OFF_TAG_LO), 8'hc1);
        rd(8'ha0, 8'h77);
        rd(cb(4'd11, LN), 8'h20);
        sch(4'd6, 12'h200, 4'h2, 7'h30, 2'b00, 12'hfff);
        sch(4'd8, 12'h300, 4'h2, 7'h38, 2'b10, 12'hfff);
        wr(8'hb1, 8'h3c);
        evt_q.push_back(4'd6);
        rxf(12'h200, 3'b011, 0, 5'd1, 1'b1, 1'b1);
        // The engine is still idle, so the reply byte index is zero here.
        #1 cmp(tx_byte_out, 8'h3c);
        evt_q.push_back(4'd8);
        rxf(12'h300, 3'b011, 0, 5'd1, 1'b1, 1'b0);
        rd(cb(4'd6, LN), 8'h1b);
        rd(cb(4'd8, LN), 8'h1b);
        // Transmitting channels are set up while the engine is disabled (en low), avoiding the race.
        sch(4'd7, 12'h070, 4'h0, 7'h40, 2'b00, 12'hfff);
        sch(4'd2, 12'h020, 4'h0, 7'h48, 2'b00, 12'hfff);
        sch(4'd9, 12'h090, 4'h2, 7'h50, 2'b01, 12'hfff);
        sch(4'd4, 12'h040, 4'h3, 7'h58, 2'b00, 12'hfff);
        sch(4'd10, 12'h0a0, 4'h3, 7'h60, 2'b00, 12'hfff);
        sch(4'd12, 12'h0c0, 4'h3, 7'h68, 2'b01, 12'hfff);
        foreach (ord[i]) evt_q.push_back(ord[i]);
        // Reply bytes arrive during every transmission, so the occupied buffer is exercised.
        rmap             <= 16'h1400;
        rx_len_in        <= 5'd1;
        rx_byte_in       <= 8'h69;
        rx_byte_valid_in <= 1'b1;
        en               <= 1'b1;
        for (int i = 0; i < 400 && evt_q.size() != 0; i++) @(posedge clock_in);
        en               <= 1'b0;
        rx_byte_valid_in <= 1'b0;
        rd(cb(4'd2, LN), 8'h1a);
        rd(cb(4'd7, LN), 8'h1a);
        rd(cb(4'd9, LN), 8'h1b);
        rd(cb(4'd10, LN), 8'h1b);
        rd(8'he0, 8'h61);
        rd(cb(4'd12, LN), 8'h1b);
        rd(8'he8, 8'h5c);
        rd(8'he9, 8'h96);
        rd(cb(4'd4, LN), 8'h1a);
        evt_q.push_back(4'd4);
        rxf(12'h040, 3'b000, 2, 5'd3, 1'b1, 1'b0);
        rd(cb(4'd4, LN), 8'h1b);
        rd(8'hd8, 8'h03);
        repeat (3) @(posedge clock_in);
        cmp(8'(evt_q.size()), 8'h00);
        conclude();
    end
endmodule : vch_handler_bench
